// ---- oam_remote_command_counters_test.sv ----
// Self-checking bench of the maintenance register group.
`timescale 1ns/1ps
module oam_remote_command_counters_test;
	reg clk = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0, txv = 1'b0;
	reg hub = 1'b1;
	reg [7:0] adr = 8'h00, wd = 8'h00, mb2 = 8'h3C, r;
	wire ack, rxv, lnk, ext;
	wire [31:0] rdat;
	wire [7:0] pst, f1, f2, f3;
	wire [1:0] opc;
	integer bad_count = 0, total_checks = 0, n = 0, i;
	orc_regs dut (.clk_sys_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in({adr, 2'b00}),
		.wb_sel_in(4'h1), .wb_dat_in({24'h00_0000, wd}), .wb_dat_out(rdat),
		.wb_ack_out(ack), .hub_side_in(hub),
		.model_byte_one_in(8'h11),
		.model_byte_two_in(mb2), .model_byte_three_in(8'h77),
		.tx_frame_valid_in(txv), .rx_frame_valid_in(rxv),
		.optical_link_up_in(lnk), .partner_status_in(pst),
		.frame_model_byte_one_out(f1), .frame_model_byte_two_out(f2),
		.frame_model_byte_three_out(f3), .ext_mode_out(ext),
		.op_code_out(opc));
	orc_peer_model peer (.clk_sys_in(clk), .rx_frame_valid_out(rxv),
		.optical_link_up_out(lnk), .partner_status_out(pst));
	always #2.5 clk = ~clk;
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		n = n + 1;
		if (n == 5000) begin
			bad_count = bad_count + 1;
			wrap_up;
		end
	end
	task chk(input [7:0] got, input [7:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wb(input w, input [7:0] a, input [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		r = rdat[7:0];
		cyc <= 1'b0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(r, e);
	endtask
	task t_regs;
		rd(8'h4A, 8'h22);
		rd(8'h4F, 8'h47);
		rd(8'h40, 8'h00);
		wb(1'b1, 8'h4A, 8'h3F);
		wb(1'b1, 8'h4D, 8'h99);
		rd(8'h4A, 8'h2F);
		rd(8'h4D, 8'h00);
		$display("t_regs done");
	endtask
	task t_modes;
		reg e;
		wb(1'b1, 8'h4B, 8'hA5);
		wb(1'b1, 8'h4C, 8'h5A);
		for (i = 0; i < 16; i = i + 1) begin
			wb(1'b1, 8'h4A, i[7:0]);
			mb2 <= mb2 + 8'h01;
			repeat (3) @(posedge clk);
			e = i[1:0] == 2'b10;
			chk({5'h00, ext, opc}, {5'h00, e, i[3:2]});
			chk(f1, e ? 8'h20 | i[7:0] : 8'h11);
			chk(f2, e ? 8'hA5 : mb2);
			chk(f3, e ? 8'h5A : 8'h77);
		end
		$display("t_modes done");
	endtask
	task t_counts;
		repeat (3) @(posedge clk) txv <= 1'b1;
		@(posedge clk) txv <= 1'b0;
		peer.send(300);
		rd(8'h4D, 8'h03);
		rd(8'h4E, 8'hFF);
		wb(1'b1, 8'h44, 8'h01);
		rd(8'h4E, 8'hFF);
		wb(1'b1, 8'h44, 8'h00);
		rd(8'h4D, 8'h00);
		rd(8'h4E, 8'h00);
		$display("t_counts done");
	endtask
	task t_mirror;
		peer.link(1'b1, 8'h5C);
		rd(8'h4F, 8'h5C);
		peer.link(1'b0, 8'h5C);
		rd(8'h4F, 8'h5C);
		$display("t_mirror done");
	endtask
	// A mid-run reset brings the block up as a subscriber side converter.
	task t_side;
		peer.send(5);
		hub <= 1'b0;
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h4E, 8'h00);
		rd(8'h4F, 8'h07);
		rd(8'h4A, 8'h22);
		chk({7'h00, ext}, 8'h00);
		chk(f1, 8'h11);
		repeat (260) @(posedge clk) txv <= 1'b1;
		@(posedge clk) txv <= 1'b0;
		rd(8'h4D, 8'hFF);
		$display("t_side done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_modes;
		t_counts;
		t_mirror;
		t_side;
		wrap_up;
	end
endmodule

// ---- orc_defines.vh ----
// Register map, field positions and reset values of the maintenance register group.
`ifndef ORC_DEFINES_VH
`define ORC_DEFINES_VH

// ==========================================================
// Register offsets (byte addresses on the bus are index * 4)
`define ORC_IDX_LOOP_CTRL 8'h44
`define ORC_IDX_CMD_MODE 8'h4A
`define ORC_IDX_CMD_ADDR 8'h4B
`define ORC_IDX_CMD_DATA 8'h4C
`define ORC_IDX_TX_COUNT 8'h4D
`define ORC_IDX_RX_COUNT 8'h4E
`define ORC_IDX_MIRROR 8'h4F

// ==========================================================
// Field positions of the mode register
`define ORC_RSV_HI 7
`define ORC_RSV_LO 6
`define ORC_CAP_HI 5
`define ORC_CAP_LO 4
`define ORC_OPC_HI 3
`define ORC_OPC_LO 2
`define ORC_MODE_HI 1
`define ORC_MODE_LO 0

// ==========================================================
// Codes and reset values
`define ORC_MODE_NORMAL 2'h0
`define ORC_MODE_EXT 2'h2
`define ORC_CAP_EXT 2'h2
`define ORC_RST_MODE_RW 8'h02
`define ORC_RST_BYTE 8'h00
`define ORC_COUNT_MAX 8'hFF
`define ORC_COUNT_ONE 8'h01
`define ORC_CLEAR_VALUE 8'h00
`define ORC_MIRROR_HUB 8'h47
`define ORC_MIRROR_SUB 8'h07
`define ORC_RW_MASK 8'hCF
`define ORC_ADR_LSB 2

`endif

// ---- orc_peer_model.sv ----
// Peer converter model on the far side of the optical link.
`timescale 1ns/1ps
module orc_peer_model (
	// Link side
	input wire clk_sys_in,
	output reg rx_frame_valid_out = 1'b0,
	output reg optical_link_up_out = 1'b0,
	output reg [7:0] partner_status_out = 8'h00
);
	task send(input integer n);
		repeat (n) @(posedge clk_sys_in) rx_frame_valid_out <= 1'b1;
		@(posedge clk_sys_in) rx_frame_valid_out <= 1'b0;
	endtask
	task link(input up, input [7:0] st);
		@(posedge clk_sys_in);
		optical_link_up_out <= up;
		partner_status_out <= up ? st : ~st;
	endtask
endmodule

// ---- orc_regs.v ----
// Remote command registers, maintenance frame counters and status mirror.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
module orc_regs (
	// Clock and reset
	input wire clk_sys_in,
	input wire rstn_in,
	// Wishbone slave
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [9:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output wire wb_ack_out,
	// Configuration
	input wire hub_side_in,
	// Own model info bytes
	input wire [7:0] model_byte_one_in,
	input wire [7:0] model_byte_two_in,
	input wire [7:0] model_byte_three_in,
	// Maintenance frame events and partner status
	input wire tx_frame_valid_in,
	input wire rx_frame_valid_in,
	input wire optical_link_up_in,
	input wire [7:0] partner_status_in,
	// Fields for the outgoing maintenance frame
	output reg [7:0] frame_model_byte_one_out,
	output reg [7:0] frame_model_byte_two_out,
	output reg [7:0] frame_model_byte_three_out,
	output reg ext_mode_out,
	output reg [1:0] op_code_out
);
`include "orc_defines.vh"

	// ==========================================================
	// Bus front end
	wire req;
	wire wr;
	wire [7:0] idx;
	wire [7:0] wbyte;
	reg [7:0] mode_q;
	reg [7:0] addr_q;
	reg [7:0] data_q;
	reg [7:0] mirror_q;
	reg strap_done_q;
	wire [7:0] tx_count;
	wire [7:0] rx_count;
	wire clear_counts;
	wire [7:0] mode_rd;
	wire ext_mode;

	assign wbyte = wb_dat_in[7:0];

	orc_wb_slave u_bus (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in),
		.wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in),
		.wb_ack_out(wb_ack_out),
		.req_out(req),
		.wr_out(wr),
		.idx_out(idx)
	);

	// ==========================================================
	// Remote command registers
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			mode_q <= `ORC_RST_MODE_RW;
			addr_q <= `ORC_RST_BYTE;
			data_q <= `ORC_RST_BYTE;
		end else if (wr) begin
			if (idx == `ORC_IDX_CMD_MODE) begin
				mode_q <= wbyte & `ORC_RW_MASK;
			end
			if (idx == `ORC_IDX_CMD_ADDR) begin
				addr_q <= wbyte;
			end
			if (idx == `ORC_IDX_CMD_DATA) begin
				data_q <= wbyte;
			end
		end
	end

	assign mode_rd = {mode_q[`ORC_RSV_HI:`ORC_RSV_LO], `ORC_CAP_EXT,
		mode_q[`ORC_OPC_HI:`ORC_MODE_LO]};

	assign ext_mode = hub_side_in &&
		(mode_q[`ORC_MODE_HI:`ORC_MODE_LO] == `ORC_MODE_EXT);

	// ==========================================================
	// Frame field selection
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			frame_model_byte_one_out <= `ORC_RST_BYTE;
			frame_model_byte_two_out <= `ORC_RST_BYTE;
			frame_model_byte_three_out <= `ORC_RST_BYTE;
			ext_mode_out <= 1'b0;
			op_code_out <= 2'h0;
		end else begin
			ext_mode_out <= ext_mode;
			op_code_out <= mode_q[`ORC_OPC_HI:`ORC_OPC_LO];
			if (ext_mode) begin
				frame_model_byte_one_out <= mode_rd;
				frame_model_byte_two_out <= addr_q;
				frame_model_byte_three_out <= data_q;
			end else begin
				frame_model_byte_one_out <= model_byte_one_in;
				frame_model_byte_two_out <= model_byte_two_in;
				frame_model_byte_three_out <= model_byte_three_in;
			end
		end
	end

	// ==========================================================
	// Maintenance frame counters
	// zero write clears
	assign clear_counts = wr && idx == `ORC_IDX_LOOP_CTRL &&
		wbyte == `ORC_CLEAR_VALUE;

	orc_sat_counter u_tx_count (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.clear_in(clear_counts),
		.event_in(tx_frame_valid_in),
		.count_out(tx_count)
	);

	orc_sat_counter u_rx_count (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.clear_in(clear_counts),
		.event_in(rx_frame_valid_in),
		.count_out(rx_count)
	);

	// ==========================================================
	// Partner status mirror
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			mirror_q <= `ORC_MIRROR_SUB;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			mirror_q <= hub_side_in ? `ORC_MIRROR_HUB : `ORC_MIRROR_SUB;
		end else if (optical_link_up_in) begin
			mirror_q <= partner_status_in;
		end
	end

	// ==========================================================
	// Read data
	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			wb_dat_out <= 32'h0000_0000;
		end else if (req) begin
			case (idx)
			`ORC_IDX_CMD_MODE: wb_dat_out <= {24'h00_0000, mode_rd};
			`ORC_IDX_CMD_ADDR: wb_dat_out <= {24'h00_0000, addr_q};
			`ORC_IDX_CMD_DATA: wb_dat_out <= {24'h00_0000, data_q};
			`ORC_IDX_TX_COUNT: wb_dat_out <= {24'h00_0000, tx_count};
			`ORC_IDX_RX_COUNT: wb_dat_out <= {24'h00_0000, rx_count};
			`ORC_IDX_MIRROR: wb_dat_out <= {24'h00_0000, mirror_q};
			default: wb_dat_out <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// ---- orc_regs_checker.sv ----
// Port-level checks of the maintenance register group.
`timescale 1ns/1ps
module orc_regs_checker (
	// Bus side
	input wire clk_sys_in,
	input wire rstn_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [9:0] wb_adr_in,
	input wire [31:0] wb_dat_out,
	input wire wb_ack_out,
	// Frame side
	input wire hub_side_in,
	input wire [7:0] model_byte_two_in,
	input wire [7:0] frame_model_byte_one_out,
	input wire [7:0] frame_model_byte_two_out,
	input wire ext_mode_out,
	input wire [1:0] op_code_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	wire rd_ack = wb_ack_out && !wb_we_in;
	wire [7:0] idx = wb_adr_in[9:2];
	wire [7:0] fb1 = frame_model_byte_one_out;
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	chk_ack_pulse: assert property (s_req |=> wb_ack_out ##1 !wb_ack_out)
		else $error("bad ack");
	chk_read_upper: assert property (rd_ack |-> wb_dat_out[31:8] == 0)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (rd_ack && idx == 8'h40 |->
		wb_dat_out == 0) else $error("unmapped read");
	chk_cap_read: assert property (rd_ack && idx == 8'h4A |->
		wb_dat_out[5:4] == 2'b10) else $error("capability bits");
	chk_norm_two: assert property ($past(rstn_in) && !ext_mode_out |->
		frame_model_byte_two_out == $past(model_byte_two_in))
		else $error("normal byte two");
	chk_ext_mode: assert property (ext_mode_out |-> hub_side_in &&
		fb1[1:0] == 2'b10) else $error("ext mode");
	chk_ext_code: assert property (ext_mode_out |->
		op_code_out == fb1[3:2]) else $error("op code");
	chk_ext_cap: assert property (ext_mode_out |-> fb1[5:4] == 2'b10)
		else $error("ext capability");
	chk_ext_hold: assert property ($past(ext_mode_out) && ext_mode_out &&
		!$past(wb_ack_out) |-> $stable(frame_model_byte_two_out))
		else $error("ext byte two");
endmodule
bind orc_regs orc_regs_checker u_chk (.clk_sys_in, .rstn_in, .wb_cyc_in,
	.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out,
	.hub_side_in, .model_byte_two_in, .frame_model_byte_one_out,
	.frame_model_byte_two_out, .ext_mode_out, .op_code_out);

// ---- orc_sat_counter.v ----
// Eight-bit saturating event counter with synchronous clear.
`timescale 1ns/1ps
module orc_sat_counter (
	// Clock and reset
	input wire clk_sys_in,
	input wire rstn_in,
	// Control
	input wire clear_in,
	input wire event_in,
	// Count
	output reg [7:0] count_out
);
`include "orc_defines.vh"

	always @(posedge clk_sys_in) begin
		if (!rstn_in || clear_in) begin
			count_out <= `ORC_RST_BYTE;
		end else if (event_in && count_out != `ORC_COUNT_MAX) begin
			count_out <= count_out + `ORC_COUNT_ONE;
		end
	end
endmodule

// ---- orc_wb_slave.v ----
// Classic Wishbone slave front end: decode and one-cycle acknowledge.
`timescale 1ns/1ps
module orc_wb_slave (
	// Clock and reset
	input wire clk_sys_in,
	input wire rstn_in,
	// Wishbone
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [9:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	output reg wb_ack_out,
	// Register side
	output wire req_out,
	output wire wr_out,
	output wire [7:0] idx_out
);
`include "orc_defines.vh"

	// A request is served once; ack drops the cycle after it was given.
	assign req_out = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wr_out = req_out && wb_we_in && wb_sel_in[0];
	assign idx_out = wb_adr_in[9:`ORC_ADR_LSB];

	always @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= req_out;
		end
	end
endmodule
